// file: rtl/fcg_pkg.sv
// How it works
// - reset starts in self-clocked mode immediately
// - off mode holds main output static
// - self-clocked: open loop, stored filter value
// - internal loop mode multiplies internal reference
// - engaged modes pass unlocked then locked
// - bypass mode outputs external reference directly
// - external loop mode multiplies external reference
// - bus divider, eight powers of two: 1 passes main output, 2 to 128 divide the core clock
// - lock acquired and lock lost status
// - external reference validity monitor
// - loss raises reset or interrupt, configurable
// - loop output auto engaged after lock
// - oscillator keeps setting across stop
// - oscillator holds frequency on reference loss
// - non-running source cannot be selected
// - input pin used only if external first
// - output pin used only if external first
// - gain select one gives high amplitude
// - 8 MHz source selectable as debug clock
// - 243 kHz reference trimmable by software
// - separate self-clocked real-time interrupt source
// - drive fixed-frequency enable and secondary clocks
// - mode codes 00,01,10,11
// - range selects prescale 64 or 1
// - gain, range, reference bits write once
// - internal first write blocks external modes
package fcg_pkg;
	// =========================================
	// mode encodings
	typedef enum logic [1:0]
	{
		FCG_SELF_CLOCKED   = 2'h0,
		FCG_ENGAGED_INT    = 2'h1,
		FCG_BYPASSED_EXT   = 2'h2,
		FCG_ENGAGED_EXT    = 2'h3
	} fcg_mode_type;

	// =========================================
	// constants
	localparam int          FCG_PRESCALE_LOW   = 64;
	localparam int          FCG_PRESCALE_HIGH  = 1;
	localparam int          FCG_CNT_W          = 16;
	localparam int          FCG_FILT_W         = 12;
	localparam logic [11:0] FCG_FILT_RESET     = 12'h800;
	localparam logic [15:0] FCG_LOCK_TOL       = 16'h0004;
	localparam logic [15:0] FCG_LOSS_LIMIT     = 16'h0100;
	localparam logic [2:0]  FCG_DIV_MAX        = 3'h7;
	localparam int          FCG_DBG_FAST_MHZ   = 8;
	localparam int          FCG_REF_KHZ        = 243;

	// =========================================
	// control and status bundles
	typedef struct packed
	{
		logic        wr;
		logic        gain_sel;
		logic        range_sel;
		logic        ref_sel;
		logic [1:0]  mode_sel;
		logic        loss_disable;
		logic        loss_reset_en;
		logic [2:0]  bus_div;
		logic [7:0]  mult;
	} fcg_ctrl_type;

	typedef struct packed
	{
		logic        locked;
		logic        lock_lost;
		logic        ref_valid;
		logic        ref_lost;
		logic [1:0]  mode_active;
	} fcg_stat_type;
endpackage

// file: rtl/fcg_clock_generator.sv
`timescale 1ns/10ps
module fcg_clock_generator
#(
	parameter int                  WIN_W     = 10,
	parameter logic [WIN_W-1:0]    WIN_LEN   = 10'h3FF
)
(
	input  wire logic                   core_clk_i,
	input  wire logic                   arst_n_i,
	input  wire fcg_pkg::fcg_ctrl_type  ctrl_i,
	input  wire logic                   stop_i,
	input  wire logic                   osc_in_pin_i,
	input  wire logic                   int_ref_clk_i,
	input  wire logic                   dco_clk_i,
	input  wire logic                   dbg_fast_sel_i,
	input  wire logic [7:0]             internal_reference_trim_i,
	output fcg_pkg::fcg_stat_type       stat_o,
	output logic [11:0]                 dco_filter_o,
	output logic [7:0]                  ref_trim_o,
	output logic                        osc_in_pin_used_o,
	output logic                        osc_out_pin_used_o,
	output logic                        osc_high_gain_o,
	output logic                        osc_range_high_o,
	output logic [6:0]                  prescale_o,
	output logic                        generator_main_output_o,
	output logic                        bus_clk_o,
	output logic                        loop_multiplied_clock_o,
	output logic                        external_reference_clock_o,
	output logic                        debug_local_clock_o,
	output logic                        fixed_frequency_enable_o,
	output logic                        rti_clk_o,
	output logic                        loss_reset_o,
	output logic                        loss_irq_o
);
	// =========================================
	// state
	typedef struct packed
	{
		logic [2:0]                    ext_sync;
		logic [2:0]                    ref_sync;
		logic [2:0]                    dco_sync;
		logic                          first_done;
		logic                          ext_reserved;
		logic                          gain_sel;
		logic                          range_sel;
		logic                          ref_sel;
		logic [1:0]                    mode_req;
		logic [1:0]                    mode_act;
		logic                          src_loop;
		logic [WIN_W-1:0]              win_cnt;
		logic [15:0]                   dco_cnt;
		logic [15:0]                   ext_idle;
		logic [11:0]                   filter;
		logic                          locked;
		logic                          lock_lost;
		logic                          ref_valid;
		logic                          ref_lost;
		logic [7:0]                    trim;
		logic [7:0]                    div_cnt;
		logic                          bus_clk;
		logic                          main_clk;
		logic                          loss_rst;
		logic                          loss_irq;
		logic                          main_src_ext;
		logic                          sw_park;
		logic [2:0]                    div_sel;
	} fcg_state_type;

	fcg_state_type st_ff;
	fcg_state_type nxt_st;

	function automatic logic is_external(input logic [1:0] m);
		is_external = m[1];
	endfunction

	function automatic logic is_engaged(input logic [1:0] m);
		is_engaged = m[0];
	endfunction

	// count against target, with the lock tolerance either side
	function automatic logic in_window(input logic [15:0] cnt, input logic [15:0] tgt);
		in_window = (cnt + fcg_pkg::FCG_LOCK_TOL >= tgt) &&
			(cnt <= tgt + fcg_pkg::FCG_LOCK_TOL);
	endfunction

	logic        ref_edge;
	logic        dco_edge;
	logic        ext_edge;
	logic [15:0] target;
	logic [1:0]  want;
	logic        want_ext;
	logic        old_lvl;
	logic        new_lvl;

	// =========================================
	// next state
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.ext_sync = {st_ff.ext_sync[1:0], osc_in_pin_i};
		nxt_st.ref_sync = {st_ff.ref_sync[1:0], int_ref_clk_i};
		nxt_st.dco_sync = {st_ff.dco_sync[1:0], dco_clk_i};
		ext_edge = st_ff.ext_sync[1] & ~st_ff.ext_sync[2];
		ref_edge = st_ff.ref_sync[1] & ~st_ff.ref_sync[2];
		dco_edge = st_ff.dco_sync[1] & ~st_ff.dco_sync[2];
		nxt_st.trim = internal_reference_trim_i;
		want = ctrl_i.mode_sel;
		if (ctrl_i.wr)
		begin
			if (!st_ff.first_done)
			begin
				nxt_st.first_done = 1'b1;
				nxt_st.gain_sel = ctrl_i.gain_sel;
				nxt_st.range_sel = ctrl_i.range_sel;
				nxt_st.ref_sel = ctrl_i.ref_sel;
				nxt_st.ext_reserved = is_external(want);
				nxt_st.mode_req = want;
			end
			else if (st_ff.ext_reserved || !is_external(want))
			begin
				// pin not reserved by the first write: external codes are dropped
				nxt_st.mode_req = want;
			end
		end
		// =========================================
		// external clock monitor
		if (ext_edge)
		begin
			nxt_st.ext_idle = '0;
		end
		else if (st_ff.ext_idle != fcg_pkg::FCG_LOSS_LIMIT)
		begin
			nxt_st.ext_idle = st_ff.ext_idle + 16'h0001;
		end
		nxt_st.ref_valid = st_ff.ext_reserved &&
			(st_ff.ext_idle != fcg_pkg::FCG_LOSS_LIMIT);
		// a loss in the same cycle as a write wins over the clear
		if (is_external(st_ff.mode_act) && st_ff.ref_valid && !nxt_st.ref_valid)
		begin
			nxt_st.ref_lost = 1'b1;
		end
		else if (ctrl_i.wr)
		begin
			nxt_st.ref_lost = 1'b0;
		end
		// =========================================
		// mode: switch only to running source
		if (is_external(st_ff.mode_req) && !st_ff.ref_valid)
		begin
			nxt_st.mode_act = (st_ff.mode_act == fcg_pkg::FCG_BYPASSED_EXT) ?
				fcg_pkg::FCG_SELF_CLOCKED : st_ff.mode_act;
		end
		else
		begin
			nxt_st.mode_act = st_ff.mode_req;
		end
		// =========================================
		// frequency loop: count dco edges per reference window
		target = 16'(ctrl_i.mult) * 16'(st_ff.range_sel ?
			fcg_pkg::FCG_PRESCALE_HIGH : fcg_pkg::FCG_PRESCALE_LOW);
		if (dco_edge)
		begin
			nxt_st.dco_cnt = st_ff.dco_cnt + 16'h0001;
		end
		if ((is_external(st_ff.mode_act) ? ext_edge : ref_edge))
		begin
			nxt_st.win_cnt = st_ff.win_cnt + 1'b1;
		end
		if (!is_engaged(st_ff.mode_act) || stop_i)
		begin
			nxt_st.win_cnt = '0;
			nxt_st.dco_cnt = '0;
			nxt_st.locked = 1'b0;
		end
		else if (is_external(st_ff.mode_act) && !st_ff.ref_valid)
		begin
			nxt_st.win_cnt = '0;
			nxt_st.dco_cnt = '0;
		end
		else if (st_ff.win_cnt == WIN_LEN)
		begin
			nxt_st.win_cnt = '0;
			nxt_st.dco_cnt = '0;
			if (!in_window(st_ff.dco_cnt, target))
			begin
				// one step per window keeps the loop slow but stable
				if (st_ff.dco_cnt < target)
					nxt_st.filter = st_ff.filter + 12'h001;
				else
					nxt_st.filter = st_ff.filter - 12'h001;
			end
			nxt_st.locked = in_window(st_ff.dco_cnt, target);
			if (st_ff.locked && !nxt_st.locked)
			begin
				nxt_st.lock_lost = 1'b1;
			end
		end
		// a lock loss in the same cycle as a write wins over the clear
		if (ctrl_i.wr && !(st_ff.locked && !nxt_st.locked))
		begin
			nxt_st.lock_lost = 1'b0;
		end
		// =========================================
		// loop output engaged only once locked
		nxt_st.src_loop = is_engaged(st_ff.mode_act) && st_ff.locked;
		// =========================================
		// bus divider
		// a new divisor is taken only when the counter wraps, so a change between
		// nonzero divisors never cuts a bus clock phase short
		nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
		if (&st_ff.div_cnt)
		begin
			nxt_st.div_sel = ctrl_i.bus_div;
		end
		// =========================================
		// main clock switch
		// the old source finishes its high phase, the output parks low, and the
		// new source is taken on its own low phase; a source stuck high would
		// keep the switch waiting; the running-source check stops this only for a new external source, not an old one
		want_ext = (st_ff.mode_act == fcg_pkg::FCG_BYPASSED_EXT);
		old_lvl = st_ff.main_src_ext ? st_ff.ext_sync[2] : st_ff.dco_sync[2];
		new_lvl = want_ext ? st_ff.ext_sync[2] : st_ff.dco_sync[2];
		if (stop_i)
		begin
			nxt_st.main_clk = st_ff.main_clk;
		end
		else if (want_ext == st_ff.main_src_ext)
		begin
			nxt_st.main_clk = old_lvl;
			nxt_st.sw_park = 1'b0;
		end
		else if (!st_ff.sw_park)
		begin
			nxt_st.main_clk = old_lvl;
			nxt_st.sw_park = !old_lvl;
		end
		else
		begin
			nxt_st.main_clk = 1'b0;
			if (!new_lvl)
				nxt_st.main_src_ext = want_ext;
		end
		// =========================================
		// bus clock
		if (stop_i)
		begin
			nxt_st.bus_clk = st_ff.bus_clk;
		end
		else if (st_ff.div_sel == 3'h0)
		begin
			nxt_st.bus_clk = nxt_st.main_clk;
		end
		else
		begin
			nxt_st.bus_clk = st_ff.div_cnt[st_ff.div_sel - 3'h1];
		end
		// =========================================
		// loss handling
		nxt_st.loss_rst = 1'b0;
		nxt_st.loss_irq = 1'b0;
		if (!ctrl_i.loss_disable && (nxt_st.ref_lost && !st_ff.ref_lost ||
			nxt_st.lock_lost && !st_ff.lock_lost))
		begin
			nxt_st.loss_rst = ctrl_i.loss_reset_en;
			nxt_st.loss_irq = !ctrl_i.loss_reset_en;
		end
	end

	// =========================================
	// registers
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_ff <= '0;
			st_ff.filter <= fcg_pkg::FCG_FILT_RESET;
			st_ff.mode_req <= fcg_pkg::FCG_SELF_CLOCKED;
			st_ff.mode_act <= fcg_pkg::FCG_SELF_CLOCKED;
			st_ff.main_src_ext <= 1'b0;
			st_ff.sw_park <= 1'b0;
			st_ff.div_sel <= 3'h0;
		end
		else
			st_ff <= nxt_st;
	end

	// =========================================
	// outputs
	always_comb
	begin
		stat_o.locked = st_ff.locked;
		stat_o.lock_lost = st_ff.lock_lost;
		stat_o.ref_valid = st_ff.ref_valid;
		stat_o.ref_lost = st_ff.ref_lost;
		stat_o.mode_active = st_ff.mode_act;
	end

	// =========================================
	// loop settings
	assign dco_filter_o = st_ff.filter;
	assign ref_trim_o = st_ff.trim;

	// =========================================
	// pin roles, fixed by the first write
	assign osc_in_pin_used_o = st_ff.ext_reserved;
	assign osc_out_pin_used_o = st_ff.ext_reserved;
	assign osc_high_gain_o = st_ff.gain_sel;
	assign osc_range_high_o = st_ff.range_sel;
	assign prescale_o = st_ff.range_sel ? 7'(fcg_pkg::FCG_PRESCALE_HIGH) :
		7'(fcg_pkg::FCG_PRESCALE_LOW);

	// =========================================
	// clocks, oversampled by the core clock
	assign generator_main_output_o = st_ff.main_clk;
	assign bus_clk_o = st_ff.bus_clk;
	assign loop_multiplied_clock_o = st_ff.dco_sync[2] & st_ff.src_loop;
	assign external_reference_clock_o = st_ff.ext_sync[2] & st_ff.ref_valid;
	assign debug_local_clock_o = dbg_fast_sel_i ? st_ff.dco_sync[2] :
		st_ff.ref_sync[2];
	assign fixed_frequency_enable_o = st_ff.ref_sync[1] & ~st_ff.ref_sync[2];
	assign rti_clk_o = st_ff.ref_sync[2];

	// =========================================
	// loss events
	assign loss_reset_o = st_ff.loss_rst;
	assign loss_irq_o = st_ff.loss_irq;
endmodule

// file: testbench/fcg_assertions.sv
`timescale 1ns/10ps
module fcg_assertions
(
	input wire logic                  core_clk_i,
	input wire logic                  arst_n_i,
	input wire fcg_pkg::fcg_ctrl_type ctrl_i,
	input wire logic                  stop_i,
	input wire fcg_pkg::fcg_stat_type stat_o,
	input wire logic                  osc_high_gain_o,
	input wire logic                  osc_range_high_o,
	input wire logic [6:0]            prescale_o,
	input wire logic                  generator_main_output_o,
	input wire logic                  fixed_frequency_enable_o,
	input wire logic                  loss_reset_o,
	input wire logic                  loss_irq_o
);
	// =========================================
	// first write tracking
	logic seen_ff;
	logic int_first_ff;
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			seen_ff      <= 1'b0;
			int_first_ff <= 1'b0;
		end
		else if (ctrl_i.wr && !seen_ff)
		begin
			seen_ff      <= 1'b1;
			int_first_ff <= !ctrl_i.mode_sel[1];
		end
	end
	// =========================================
	// properties
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	a_self_before_write: assert property (!seen_ff |-> stat_o.mode_active == 2'h0)
		else $error("mode left self-clocked before any write");
	a_prescale_range: assert property (prescale_o == (osc_range_high_o ? 7'h01 : 7'h40))
		else $error("prescale does not match range");
	// two spare cycles let the first write land before freezing
	a_bits_write_once: assert property (seen_ff ##2 1 |=> $stable({osc_high_gain_o, osc_range_high_o}))
		else $error("write-once bit changed");
	a_internal_blocks_ext: assert property (int_first_ff |-> !stat_o.mode_active[1])
		else $error("external mode after internal first write");
	a_bypass_needs_ref: assert property (!stat_o.ref_valid [*3] |-> stat_o.mode_active != 2'h2)
		else $error("bypass kept without valid reference");
	a_loss_has_cause: assert property (loss_reset_o || loss_irq_o |-> ##[0:2] (stat_o.ref_lost || stat_o.lock_lost))
		else $error("loss event without loss flag");
	a_stop_freezes: assert property (stop_i [*3] |-> $stable(generator_main_output_o))
		else $error("main output moved in stop");
	a_ffe_pulse_short: assert property (fixed_frequency_enable_o |=> !fixed_frequency_enable_o)
		else $error("fixed frequency enable longer than a cycle");
	cover property (stat_o.mode_active == 2'h2);
	cover property (loss_irq_o);
	cover property (loss_reset_o);
endmodule
bind fcg_clock_generator fcg_assertions u_chk (.*);

// file: testbench/fcg_ext_osc.sv
`timescale 1ns/10ps
module fcg_ext_osc
#(
	parameter realtime HALF = 150ns
)
(
	input  wire logic run_i,
	output logic      clk_o
);
	// a stopped source rests low, as an idle clock pin would
	initial clk_o = 1'b0;
	always
	begin
		#(HALF);
		clk_o = run_i ? !clk_o : 1'b0;
	end
endmodule

// file: testbench/fcg_clock_generator_test.sv
`timescale 1ns/10ps
module fcg_clock_generator_test;
	logic                  clk, arst_n, stop, iref, digitally_controlled_oscillator, run, system_fixed_frequency_clock, gain, rhi, lrst, lirq, mclk;
	fcg_pkg::fcg_ctrl_type ctrl;
	fcg_pkg::fcg_stat_type st;
	logic [11:0]           filt;
	logic [7:0]            trim;
	logic [6:0]            pre;
	logic                  iu, ou, bclk, lclk;
	int                    err_total, num_checks, cycles;
	fcg_ext_osc osc (.run_i(run), .clk_o(system_fixed_frequency_clock));
	fcg_clock_generator #(.WIN_W(10), .WIN_LEN(10'h007)) uut
	(
		.core_clk_i(clk), .arst_n_i(arst_n), .ctrl_i(ctrl), .stop_i(stop),
		.osc_in_pin_i(system_fixed_frequency_clock), .int_ref_clk_i(iref), .dco_clk_i(digitally_controlled_oscillator), .dbg_fast_sel_i(1'b1),
		.internal_reference_trim_i(8'h5A), .stat_o(st), .dco_filter_o(filt), .ref_trim_o(trim),
		.osc_in_pin_used_o(iu), .osc_out_pin_used_o(ou), .osc_high_gain_o(gain),
		.osc_range_high_o(rhi), .prescale_o(pre), .generator_main_output_o(mclk),
		.bus_clk_o(bclk), .loop_multiplied_clock_o(lclk), .external_reference_clock_o(),
		.debug_local_clock_o(), .fixed_frequency_enable_o(), .rti_clk_o(),
		.loss_reset_o(lrst), .loss_irq_o(lirq)
	);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	initial
	begin
		iref = 1'b0;
		digitally_controlled_oscillator = 1'b0;
		fork
			forever #200 iref = !iref;
			forever #31 digitally_controlled_oscillator = !digitally_controlled_oscillator;
		join
	end
	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 10000)
		begin
			err_total = err_total + 1;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic do_reset();
		arst_n = 1'b0;
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
	endtask
	task automatic wr(input logic [1:0] m, input logic g, input logic r, input logic e);
		ctrl = '{wr:1'b1, gain_sel:g, range_sel:r, ref_sel:1'b0, mode_sel:m, loss_disable:1'b0,
			loss_reset_en:e, bus_div:3'h3, mult:8'h10};
		@(negedge clk);
		ctrl.wr = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic test_internal();
		logic held;
		check("mode", 2'h0, st.mode_active);
		check("filter", 12'h800, filt);
		check("trim", 8'h5A, trim);
		wr(2'h1, 1'b0, 1'b1, 1'b0);
		check("mode", 2'h1, st.mode_active);
		check("pins", 2'h0, {iu, ou});
		check("prescale", 7'h01, pre);
		wr(2'h3, 1'b1, 1'b0, 1'b0);
		check("mode", 2'h1, st.mode_active);
		check("gain range", 2'h1, {gain, rhi});
		wr(2'h0, 1'b0, 1'b0, 1'b0);
		check("mode", 2'h0, st.mode_active);
		stop = 1'b1;
		repeat (3) @(negedge clk);
		held = mclk;
		repeat (20) @(negedge clk);
		check("main held", held, mclk);
		check("filter kept", 12'h800, filt);
		stop = 1'b0;
		$display("internal and stop test done");
	endtask
	task automatic test_lock();
		logic seen;
		logic prev;
		int   n;
		int   rises;
		seen = 1'b0;
		rises = 0;
		wr(2'h1, 1'b0, 1'b1, 1'b0);
		ctrl.mult = 8'h2D;
		for (n = 0; n < 1000 && st.locked !== 1'b1; n++)
			@(negedge clk);
		check("locked", 1'b1, st.locked);
		check("no loss yet", 1'b0, st.lock_lost);
		prev = bclk;
		for (n = 0; n < 64; n++)
		begin
			@(negedge clk);
			seen = seen | lclk;
			rises = rises + (bclk && !prev);
			prev = bclk;
		end
		check("loop clock", 1'b1, seen);
		check("bus rises", 16'h0008, rises[15:0]);
		seen = 1'b0;
		ctrl.mult = 8'h10;
		for (n = 0; n < 700 && st.lock_lost !== 1'b1; n++)
		begin
			@(negedge clk);
			seen = seen | lirq;
		end
		check("lock lost", 2'h2, {st.lock_lost, st.locked});
		check("lock irq", 1'b1, seen);
		$display("lock test done");
	endtask
	task automatic test_ext(input logic e);
		logic r;
		logic q;
		int   n;
		r = 1'b0;
		q = 1'b0;
		do_reset();
		run = 1'b1;
		wr(2'h2, 1'b1, 1'b0, e);
		for (n = 0; n < 400 && st.mode_active !== 2'h2; n++)
			@(negedge clk);
		check("mode", 2'h2, st.mode_active);
		check("valid", 1'b1, st.ref_valid);
		check("pins gain", 3'h7, {iu, ou, gain});
		check("prescale", 7'h40, pre);
		run = 1'b0;
		for (n = 0; n < 800 && !(r || q); n++)
		begin
			@(negedge clk);
			r = lrst;
			q = lirq;
		end
		check("loss kind", {e, !e}, {r, q});
		repeat (4) @(negedge clk);
		check("lost mode", 3'h4, {st.ref_lost, st.mode_active});
		$display("external loss test done");
	endtask
	initial
	begin
		{err_total, num_checks, cycles} = '0;
		{stop, run} = 2'h0;
		ctrl = '0;
		do_reset();
		repeat (4) @(negedge clk);
		test_internal();
		test_lock();
		test_ext(1'b0);
		test_ext(1'b1);
		give_verdict();
	end
endmodule
